// ===== src/flash_front_pkg.sv
// constants, opcodes and enumerations of the serial flash front end
package flash_front_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_READ4 = 8'h13;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_PROG4 = 8'h12;
  localparam logic [7:0] OPC_SECT = 8'h20;
  localparam logic [7:0] OPC_SECT4 = 8'h21;
  localparam logic [7:0] OPC_BLK32 = 8'h52;
  localparam logic [7:0] OPC_BLK64 = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hC7;
  localparam logic [7:0] OPC_ENTER_SEC = 8'hB1;
  localparam logic [7:0] OPC_EXIT_SEC = 8'hC1;
  localparam logic [7:0] OPC_WR_SEC = 8'h2F;
  localparam logic [7:0] OPC_RD_SEC = 8'h2B;
  localparam logic [7:0] OPC_ENTER_WIDE = 8'hB7;
  localparam logic [7:0] OPC_EXIT_WIDE = 8'hE9;
  localparam logic [7:0] OPC_WR_SEG = 8'hC5;
  localparam logic [7:0] OPC_RD_SEG = 8'hC8;
  localparam logic [7:0] OPC_ENTER_QUAD = 8'h35;
  localparam logic [7:0] OPC_EXIT_QUAD = 8'hF5;
  // ---------------------------------------------------------------
  // geometry and field positions
  // ---------------------------------------------------------------
  localparam int ARR_AW = 26;
  localparam int BLK_LSB = 16;
  localparam logic [10:0] BLK_COUNT = 11'h400;
  localparam logic [3:0] LEVEL_ALL = 4'hB;
  localparam int OTP_HALF_BIT = 9;
  localparam int SEC_FACTORY_BIT = 0;
  localparam int SEC_CUST_BIT = 1;
  localparam logic [2:0] ADDR_LEN3 = 3'h3;
  localparam logic [2:0] ADDR_LEN4 = 3'h4;
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;
  localparam logic [1:0] SEG_RESET = 2'h0;
  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {OPK_PROG, OPK_SECT, OPK_BLK32, OPK_BLK64, OPK_CHIP} op_kind_e;
  typedef enum logic [2:0] {CL_BAD, CL_NOARG, CL_ADDR_END, CL_ADDR_IN, CL_ADDR_OUT, CL_IN, CL_OUT} cmd_class_e;
  typedef enum logic [1:0] {RS_ARRAY, RS_SEC, RS_SEG} rd_src_e;
endpackage : flash_front_pkg

// ===== src/flash_front.sv
// serial flash command front end: protection, secured area, addressing, quad mode
`timescale 1ns/10ps
`default_nettype none
module flash_front (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_n,
  input wire logic [3:0] prot_level,
  input wire logic prot_bottom,
  input wire logic factory_lock,
  input wire logic busy,
  input wire logic [7:0] arr_rdata,
  output logic [25:0] arr_addr,
  output logic arr_otp,
  output logic op_valid,
  output flash_front_pkg::op_kind_e op_kind,
  output logic [25:0] op_addr,
  output logic [7:0] op_data,
  output logic op_otp,
  output logic cmd_reject,
  output logic quad_mode,
  output logic wide_mode,
  output logic secured_mode
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DIN, ST_END, ST_DOUT, ST_IGNORE} state_e;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic flash_front_pkg::cmd_class_e cls_of(input logic [7:0] op, input logic quad);
    case (op)
      flash_front_pkg::OPC_READ, flash_front_pkg::OPC_READ4: cls_of = flash_front_pkg::CL_ADDR_OUT;
      flash_front_pkg::OPC_PROG, flash_front_pkg::OPC_PROG4: cls_of = flash_front_pkg::CL_ADDR_IN;
      flash_front_pkg::OPC_SECT, flash_front_pkg::OPC_SECT4,
      flash_front_pkg::OPC_BLK32, flash_front_pkg::OPC_BLK64: cls_of = flash_front_pkg::CL_ADDR_END;
      flash_front_pkg::OPC_CHIP_A, flash_front_pkg::OPC_CHIP_B,
      flash_front_pkg::OPC_ENTER_SEC, flash_front_pkg::OPC_EXIT_SEC, flash_front_pkg::OPC_WR_SEC,
      flash_front_pkg::OPC_ENTER_WIDE, flash_front_pkg::OPC_EXIT_WIDE: cls_of = flash_front_pkg::CL_NOARG;
      flash_front_pkg::OPC_ENTER_QUAD: cls_of = quad ? flash_front_pkg::CL_BAD : flash_front_pkg::CL_NOARG;
      flash_front_pkg::OPC_EXIT_QUAD: cls_of = quad ? flash_front_pkg::CL_NOARG : flash_front_pkg::CL_BAD;
      flash_front_pkg::OPC_WR_SEG: cls_of = flash_front_pkg::CL_IN;
      flash_front_pkg::OPC_RD_SEC, flash_front_pkg::OPC_RD_SEG: cls_of = flash_front_pkg::CL_OUT;
      default: cls_of = flash_front_pkg::CL_BAD;
    endcase
  endfunction : cls_of

  function automatic logic is4b(input logic [7:0] op);
    is4b = (op == flash_front_pkg::OPC_READ4) || (op == flash_front_pkg::OPC_PROG4) ||
           (op == flash_front_pkg::OPC_SECT4);
  endfunction : is4b

  function automatic logic prot_hit(input logic [3:0] lvl, input logic bottom, input logic [9:0] blk);
    logic [10:0] n;
    n = 11'h1 << (lvl - 4'h1);
    if (lvl == 4'h0) prot_hit = 1'b0;
    else if (lvl >= flash_front_pkg::LEVEL_ALL) prot_hit = 1'b1;
    else if (bottom) prot_hit = {1'b0, blk} < n;
    else prot_hit = {1'b0, blk} >= (flash_front_pkg::BLK_COUNT - n);
  endfunction : prot_hit

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] sclk_sr;
  logic [2:0] csn_sr;
  logic [3:0] sio_s1;
  logic [3:0] sio_s2;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_sr <= 3'h0;
      csn_sr <= 3'h7;
      sio_s1 <= 4'h0;
      sio_s2 <= 4'h0;
    end else begin
      sclk_sr <= {sclk_sr[1:0], sclk};
      csn_sr <= {csn_sr[1:0], cs_n};
      sio_s1 <= sio_in;
      sio_s2 <= sio_s1;
    end
  end
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  assign sck_rise = sclk_sr[1] & ~sclk_sr[2];
  assign sck_fall = ~sclk_sr[1] & sclk_sr[2];
  assign cs_fall = ~csn_sr[1] & csn_sr[2];
  assign cs_rise = csn_sr[1] & ~csn_sr[2];

  // ---------------------------------------------------------------
  // command receiver
  // ---------------------------------------------------------------
  state_e st_reg;
  flash_front_pkg::cmd_class_e cls_reg, cls_next;
  flash_front_pkg::rd_src_e src_reg;
  logic [7:0] sh_reg, sh_next, cmd_reg, data_reg;
  logic [2:0] bit_reg, bit_next, step, byte_reg, len_reg, len_next;
  logic [23:0] addr_sh;
  logic [31:0] full_addr;
  logic [25:0] addr_reg, eff_addr;
  logic got_reg, byte_done, addr_done, to_ignore, is_arr;
  logic wide_reg, quad_reg, sec_reg, cust_reg;
  logic [1:0] seg_reg;

  assign step = quad_reg ? flash_front_pkg::STEP_QUAD : flash_front_pkg::STEP_SINGLE;
  assign sh_next = quad_reg ? {sh_reg[3:0], sio_s2} : {sh_reg[6:0], sio_s2[0]};
  assign bit_next = bit_reg + step;
  assign byte_done = sck_rise && (bit_next == 3'h0);
  assign cls_next = cls_of(sh_next, quad_reg);
  assign len_next = (wide_reg || is4b(sh_next)) ? flash_front_pkg::ADDR_LEN4
                                               : flash_front_pkg::ADDR_LEN3;
  assign is_arr = (cls_next == flash_front_pkg::CL_ADDR_OUT) || (cls_next == flash_front_pkg::CL_ADDR_IN) ||
                  (cls_next == flash_front_pkg::CL_ADDR_END) || (sh_next == flash_front_pkg::OPC_CHIP_A) ||
                  (sh_next == flash_front_pkg::OPC_CHIP_B);
  assign to_ignore = (cls_next == flash_front_pkg::CL_BAD) || (busy && is_arr);
  assign full_addr = {addr_sh, sh_next};
  assign addr_done = byte_done && (st_reg == ST_ADDR) && (byte_reg + 3'h1 == len_reg);
  // wide commands take their own bits, short ones sit in the segment
  assign eff_addr = (len_reg == flash_front_pkg::ADDR_LEN4) ? full_addr[25:0] : {seg_reg, full_addr[23:0]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
      cls_reg <= flash_front_pkg::CL_BAD;
      src_reg <= flash_front_pkg::RS_ARRAY;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      data_reg <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      len_reg <= flash_front_pkg::ADDR_LEN3;
      addr_sh <= 24'h000000;
      addr_reg <= 26'h0000000;
      got_reg <= 1'b0;
    end else if (cs_fall) begin
      st_reg <= ST_OPC;
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      got_reg <= 1'b0;
    end else if (cs_rise) begin
      st_reg <= ST_IDLE;
    end else if (sck_rise) begin
      if (st_reg == ST_OPC || st_reg == ST_ADDR || st_reg == ST_DIN) begin
        sh_reg <= sh_next;
        bit_reg <= bit_next;
      end
      case (st_reg)
        ST_OPC: begin
          if (byte_done) begin
            cmd_reg <= sh_next;
            cls_reg <= cls_next;
            len_reg <= len_next;
            src_reg <= (sh_next == flash_front_pkg::OPC_RD_SEC) ? flash_front_pkg::RS_SEC :
                       (sh_next == flash_front_pkg::OPC_RD_SEG) ? flash_front_pkg::RS_SEG : flash_front_pkg::RS_ARRAY;
            if (to_ignore) st_reg <= ST_IGNORE;
            else if (cls_next == flash_front_pkg::CL_NOARG) st_reg <= ST_END;
            else if (cls_next == flash_front_pkg::CL_IN) st_reg <= ST_DIN;
            else if (cls_next == flash_front_pkg::CL_OUT) st_reg <= ST_DOUT;
            else st_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_sh <= full_addr[23:0];
            byte_reg <= byte_reg + 3'h1;
          end
          if (addr_done) begin
            addr_reg <= eff_addr;
            if (cls_reg == flash_front_pkg::CL_ADDR_END) st_reg <= ST_END;
            else if (cls_reg == flash_front_pkg::CL_ADDR_IN) st_reg <= ST_DIN;
            else st_reg <= ST_DOUT;
          end
        end
        ST_DIN: begin
          if (byte_done) begin
            data_reg <= sh_next; // only the last byte of a burst is kept
            got_reg <= 1'b1;
            if (cls_reg == flash_front_pkg::CL_IN) st_reg <= ST_END;
          end
        end
        ST_END: st_reg <= ST_IGNORE; // bits past the command length spoil it
        ST_DOUT, ST_IGNORE, ST_IDLE: st_reg <= st_reg;
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // execution at select rise
  // ---------------------------------------------------------------
  logic fire, allow, otp_half;
  assign otp_half = addr_reg[flash_front_pkg::OTP_HALF_BIT];
  // only a boundary end of a complete command executes
  assign fire = cs_rise && ((st_reg == ST_END) ||
                (st_reg == ST_DIN && got_reg && bit_reg == 3'h0 && cls_reg == flash_front_pkg::CL_ADDR_IN));
  always_comb begin
    allow = 1'b1;
    if (cls_reg == flash_front_pkg::CL_ADDR_IN) begin
      if (sec_reg) allow = otp_half ? !factory_lock : !cust_reg;
      else allow = !prot_hit(prot_level, prot_bottom, addr_reg[25:flash_front_pkg::BLK_LSB]);
    end else if (cls_reg == flash_front_pkg::CL_ADDR_END) begin
      allow = !sec_reg && !prot_hit(prot_level, prot_bottom, addr_reg[25:flash_front_pkg::BLK_LSB]);
    end else if (cmd_reg == flash_front_pkg::OPC_CHIP_A || cmd_reg == flash_front_pkg::OPC_CHIP_B) begin
      allow = !sec_reg && (prot_level == 4'h0);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wide_reg <= 1'b0;
      quad_reg <= 1'b0;
      sec_reg <= 1'b0;
      cust_reg <= 1'b0;
      seg_reg <= flash_front_pkg::SEG_RESET;
    end else if (fire) begin
      if (cls_reg == flash_front_pkg::CL_IN) seg_reg <= data_reg[1:0];
      if (cls_reg == flash_front_pkg::CL_NOARG) begin
        case (cmd_reg)
          flash_front_pkg::OPC_ENTER_WIDE: wide_reg <= 1'b1;
          flash_front_pkg::OPC_EXIT_WIDE: wide_reg <= 1'b0;
          flash_front_pkg::OPC_ENTER_SEC: sec_reg <= 1'b1;
          flash_front_pkg::OPC_EXIT_SEC: sec_reg <= 1'b0;
          flash_front_pkg::OPC_WR_SEC: cust_reg <= 1'b1;
          flash_front_pkg::OPC_ENTER_QUAD: quad_reg <= 1'b1;
          flash_front_pkg::OPC_EXIT_QUAD: quad_reg <= 1'b0;
          default: quad_reg <= quad_reg;
        endcase
      end
    end
  end

  logic is_op;
  assign is_op = (cls_reg == flash_front_pkg::CL_ADDR_IN) || (cls_reg == flash_front_pkg::CL_ADDR_END) ||
                 (cmd_reg == flash_front_pkg::OPC_CHIP_A) || (cmd_reg == flash_front_pkg::OPC_CHIP_B);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_valid <= 1'b0;
      op_kind <= flash_front_pkg::OPK_PROG;
      op_addr <= 26'h0000000;
      op_data <= 8'h00;
      op_otp <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      op_valid <= fire && is_op && allow;
      cmd_reject <= (cs_rise && (st_reg == ST_ADDR || st_reg == ST_DIN || st_reg == ST_END) && !(fire && allow)) ||
                    (byte_done && st_reg == ST_OPC && to_ignore);
      if (fire && is_op) begin
        op_addr <= addr_reg; // no segment carry, address already wrapped inside it
        op_data <= data_reg;
        op_otp <= sec_reg;
        case (cmd_reg)
          flash_front_pkg::OPC_SECT, flash_front_pkg::OPC_SECT4: op_kind <= flash_front_pkg::OPK_SECT;
          flash_front_pkg::OPC_BLK32: op_kind <= flash_front_pkg::OPK_BLK32;
          flash_front_pkg::OPC_BLK64: op_kind <= flash_front_pkg::OPK_BLK64;
          flash_front_pkg::OPC_CHIP_A, flash_front_pkg::OPC_CHIP_B: op_kind <= flash_front_pkg::OPK_CHIP;
          default: op_kind <= flash_front_pkg::OPK_PROG;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // data output; bytes are fetched one clock after the address moves
  // ---------------------------------------------------------------
  logic [7:0] out_sh, sec_byte;
  logic [2:0] out_cnt, out_next;
  logic load_pend;
  assign sec_byte = {6'h00, cust_reg, factory_lock};
  assign out_next = out_cnt + step;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_sh <= 8'h00;
      out_cnt <= 3'h0;
      load_pend <= 1'b0;
      arr_addr <= 26'h0000000;
      arr_otp <= 1'b0;
      sio_out <= 4'h0;
      sio_oe_n <= 4'hF;
    end else if (cs_fall || cs_rise) begin
      out_cnt <= 3'h0;
      load_pend <= 1'b0;
      sio_oe_n <= 4'hF;
    end else begin
      if ((byte_done && st_reg == ST_OPC && cls_next == flash_front_pkg::CL_OUT && !to_ignore) || addr_done) begin
        load_pend <= 1'b1;
        arr_addr <= eff_addr;
        arr_otp <= sec_reg;
      end else if (load_pend) begin
        load_pend <= 1'b0;
        case (src_reg)
          flash_front_pkg::RS_SEC: out_sh <= sec_byte;
          flash_front_pkg::RS_SEG: out_sh <= {6'h00, seg_reg};
          default: out_sh <= arr_rdata;
        endcase
      end else if (st_reg == ST_DOUT && sck_fall) begin
        sio_out <= quad_reg ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
        sio_oe_n <= quad_reg ? 4'h0 : 4'hD;
        out_sh <= quad_reg ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
        out_cnt <= out_next;
        if (out_next == 3'h0) begin
          load_pend <= 1'b1;
          if (src_reg == flash_front_pkg::RS_ARRAY) arr_addr <= arr_addr + 26'h0000001;
        end
      end
    end
  end

  assign quad_mode = quad_reg;
  assign wide_mode = wide_reg;
  assign secured_mode = sec_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  quad_enter_a: assert property (fire && cmd_reg == flash_front_pkg::OPC_ENTER_QUAD |=> quad_mode)
    else $error("quad mode not entered");
  quad_exit_a: assert property (fire && cmd_reg == flash_front_pkg::OPC_EXIT_QUAD |=> !quad_mode)
    else $error("quad mode not left");
  standby_hiz_a: assert property (st_reg == ST_IGNORE |-> sio_oe_n == 4'hF)
    else $error("output driven in standby");
  select_end_a: assert property (cs_rise |=> st_reg == ST_IDLE ##1 sio_oe_n == 4'hF)
    else $error("transfer not ended at select rise");
  boundary_a: assert property (op_valid |-> $past(bit_reg) == 3'h0 && $past(cs_rise))
    else $error("operation issued off a byte boundary");
  protect_a: assert property (op_valid && !op_otp && op_kind != flash_front_pkg::OPK_CHIP
    |-> !prot_hit($past(prot_level), $past(prot_bottom), op_addr[25:16])) else $error("protected block");
  otp_lock_a: assert property (op_valid && op_otp |-> op_kind == flash_front_pkg::OPK_PROG &&
    (op_addr[9] ? !$past(factory_lock) : !$past(cust_reg))) else $error("locked secured half changed");
  busy_ignore_a: assert property (byte_done && st_reg == ST_OPC && busy && is_arr |=> st_reg == ST_IGNORE)
    else $error("array access taken while busy");
  seg_addr_a: assert property (addr_done && !wide_reg && !is4b(cmd_reg) |=> arr_addr[25:24] == $past(seg_reg))
    else $error("segment bits not applied");
  wrap_a: assert property (st_reg == ST_DOUT && sck_fall && out_next == 3'h0 && !load_pend &&
    src_reg == flash_front_pkg::RS_ARRAY |=> arr_addr == $past(arr_addr) + 26'h1 && seg_reg == $past(seg_reg))
    else $error("read address did not advance");
  read_cov: cover property (addr_done && cls_reg == flash_front_pkg::CL_ADDR_OUT);
  prog_cov: cover property (op_valid && op_kind == flash_front_pkg::OPK_PROG);
  reject_cov: cover property (cmd_reject);
  quad_cov: cover property (quad_mode && fire);
endmodule : flash_front
`default_nettype wire

// ===== test/host_model.sv
// host serial controller model that drives the link of the flash front end
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] sio_in,
  input wire logic [3:0] sio_out
);
  // half of the 160 ns link period, counted in system clocks
  localparam int HALF = 8;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sio_in = 4'h0;
  end
  task automatic frame_start();
    @(posedge clk) cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask : frame_start
  // the clock is left high after a frame, so later frames run in mode 3
  task automatic xfer(input logic [7:0] b, input logic quad, input int nb, output logic [7:0] r);
    for (int i = 0; i < (quad ? 2 : nb); i++) begin
      @(posedge clk) sclk <= 1'b0;
      sio_in <= quad ? (i == 0 ? b[7:4] : b[3:0]) : {3'h0, b[7 - i]};
      repeat (HALF) @(posedge clk);
      r = quad ? {r[3:0], sio_out} : {r[6:0], sio_out[1]};
      sclk <= 1'b1;
      repeat (HALF - 1) @(posedge clk);
    end
  endtask : xfer
  // released data lines show the inverse so a stale value is never trusted
  task automatic frame_stop();
    @(posedge clk) cs_n <= 1'b1;
    sio_in <= ~sio_in;
    repeat (2 * HALF) @(posedge clk);
  endtask : frame_stop
endmodule : host_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench of the serial flash front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, nrst, sclk, cs_n, prot_bottom, factory_lock, busy, arr_otp, op_valid, op_otp, cmd_reject;
  logic quad_mode, wide_mode, secured_mode;
  logic [3:0] sio_in, sio_out, sio_oe_n, prot_level;
  logic [7:0] arr_rdata, op_data, rd;
  logic [7:0] rdv [2];
  logic [25:0] arr_addr, op_addr;
  flash_front_pkg::op_kind_e op_kind;
  typedef struct {logic rej; logic otp; logic [25:0] a; logic [7:0] d; flash_front_pkg::op_kind_e k;} exp_s;
  exp_s expq[$];
  exp_s e;
  int fails, checks_done;
  flash_front uut (.clk, .nrst, .sclk, .cs_n, .sio_in, .sio_out, .sio_oe_n, .prot_level, .prot_bottom,
    .factory_lock, .busy, .arr_rdata, .arr_addr, .arr_otp, .op_valid, .op_kind, .op_addr, .op_data, .op_otp,
    .cmd_reject, .quad_mode, .wide_mode, .secured_mode);
  host_model host (.clk, .sclk, .cs_n, .sio_in, .sio_out);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] fdata(input logic [25:0] a);
    return a[7:0] + a[25:18];
  endfunction : fdata
  // the array answers within the clock after arr_addr moves, as the front end expects
  always_comb arr_rdata = fdata(arr_addr);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic want(input logic rej, input logic otp, input logic [25:0] a, input logic [7:0] d,
      input flash_front_pkg::op_kind_e k);
    expq.push_back('{rej, otp, a, d, k});
  endtask : want
  // extra above zero appends a short byte, ending the frame off its boundary
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd,
      input logic [7:0] d, input int extra = 0);
    host.frame_start();
    host.xfer(op, quad_mode, 8, rd);
    for (int i = na - 1; i >= 0; i--) host.xfer(a[8 * i +: 8], quad_mode, 8, rd);
    for (int i = 0; i < nd; i++) begin
      host.xfer(d, quad_mode, 8, rd);
      rdv[i % 2] = rd;
    end
    if (extra > 0) host.xfer(d, 1'b0, extra, rd);
    host.frame_stop();
  endtask : cmd
  // ---------------------------------------------------------------
  // result watcher: every pulse consumes the oldest note
  // ---------------------------------------------------------------
  // sampled mid-cycle so a one-cycle pulse is seen settled, once
  always @(negedge clk) begin
    if (op_valid === 1'b1 || cmd_reject === 1'b1) begin
      check("pending notes", expq.size() > 0, 1);
      if (expq.size() > 0) begin
        e = expq.pop_front();
        check("reject", cmd_reject, e.rej);
        if (!e.rej) begin
          check("op kind", op_kind, e.k);
          check("op otp", op_otp, e.otp);
          check("op addr", e.otp ? op_addr[9:0] : op_addr, e.otp ? e.a[9:0] : e.a);
          if (e.k == flash_front_pkg::OPK_PROG) check("op data", op_data, e.d);
        end
      end
    end
  end
  initial begin
    logic [31:0] a;
    int lim, b;
    {nrst, prot_bottom, factory_lock, busy} = 4'h0;
    prot_level = 4'h0;
    void'($urandom(32'h3CCD));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check("modes after reset", {quad_mode, wide_mode, secured_mode, sio_oe_n}, 7'h0F);
    a = $urandom();
    cmd(flash_front_pkg::OPC_WR_SEG, 0, 0, 1, 8'hFF);
    cmd(flash_front_pkg::OPC_RD_SEG, 0, 0, 1, 8'h00);
    check("segment readback", rdv[0], 8'h03);
    want(0, 0, {2'h3, a[23:0]}, a[31:24], flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_PROG, a, 3, 1, a[31:24]);
    cmd(flash_front_pkg::OPC_WR_SEG, 0, 0, 1, 8'h01);
    want(0, 0, {2'h1, a[23:12], 12'h000}, 8'h00, flash_front_pkg::OPK_SECT);
    cmd(flash_front_pkg::OPC_SECT, {a[23:12], 12'h000}, 3, 0, 8'h00);
    cmd(flash_front_pkg::OPC_READ, 32'hFFFFFF, 3, 2, 8'h00);
    check("read last byte", rdv[0], fdata(26'h1FFFFFF));
    check("read wrap byte", rdv[1], fdata(26'h2000000));
    cmd(flash_front_pkg::OPC_RD_SEG, 0, 0, 1, 8'h00);
    check("segment kept", rdv[0], 8'h01);
    $display("segment test done");
    cmd(flash_front_pkg::OPC_ENTER_WIDE, 0, 0, 0, 8'h00);
    check("wide on", wide_mode, 1);
    want(0, 0, a[25:0], a[7:0], flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_PROG, a, 4, 1, a[7:0]);
    cmd(flash_front_pkg::OPC_EXIT_WIDE, 0, 0, 0, 8'h00);
    check("wide off", wide_mode, 0);
    $display("wide address test done");
    for (int n = 0; n < 16; n++) begin
      for (int bot = 0; bot < 2; bot++) begin
        prot_level <= 4'(n);
        prot_bottom <= 1'(bot);
        lim = n == 0 ? 0 : (n > 10 ? 1024 : 1 << (n - 1));
        for (int p = 0; p < 2; p++) begin
          b = ((bot ? lim : 1024 - lim) - p) & 1023;
          a = {6'h00, 10'(b), 16'($urandom())};
          want(bot ? b < lim : b >= 1024 - lim, 0, a[25:0], a[7:0], flash_front_pkg::OPK_PROG);
          cmd(flash_front_pkg::OPC_PROG4, a, 4, 1, a[7:0]);
        end
      end
    end
    prot_level <= 4'h0;
    $display("protection test done");
    want(1, 0, 0, 0, flash_front_pkg::OPK_PROG);
    host.frame_start();
    host.xfer(8'hFF, 1'b0, 8, rd);
    host.xfer(flash_front_pkg::OPC_READ, 1'b0, 8, rd);
    check("standby oe", sio_oe_n, 4'hF);
    host.frame_stop();
    want(1, 0, 0, 0, flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_PROG, a, 3, 1, 8'h11, 3);
    busy <= 1'b1;
    want(1, 0, 0, 0, flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_READ, a, 3, 1, 8'h00);
    busy <= 1'b0;
    $display("refusal test done");
    cmd(flash_front_pkg::OPC_ENTER_SEC, 0, 0, 0, 8'h00);
    check("secured on", secured_mode, 1);
    want(0, 1, 26'h010, 8'hC3, flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_PROG, 32'h010, 3, 1, 8'hC3);
    factory_lock <= 1'b1;
    want(1, 0, 0, 0, flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_PROG, 32'h210, 3, 1, 8'h3C);
    want(1, 0, 0, 0, flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_SECT, 0, 3, 0, 8'h00);
    cmd(flash_front_pkg::OPC_WR_SEC, 0, 0, 0, 8'h00);
    want(1, 0, 0, 0, flash_front_pkg::OPK_PROG);
    cmd(flash_front_pkg::OPC_PROG, 32'h1FF, 3, 1, 8'h5A);
    cmd(flash_front_pkg::OPC_RD_SEC, 0, 0, 0, 8'h00, 3);
    check("cut read oe", sio_oe_n, 4'hF);
    cmd(flash_front_pkg::OPC_RD_SEC, 0, 0, 1, 8'h00);
    check("security status", rdv[0], 8'h03);
    check("read targets secured", arr_otp, 1);
    cmd(flash_front_pkg::OPC_EXIT_SEC, 0, 0, 0, 8'h00);
    check("secured off", secured_mode, 0);
    $display("secured area test done");
    cmd(flash_front_pkg::OPC_ENTER_QUAD, 0, 0, 0, 8'h00);
    check("quad on", quad_mode, 1);
    cmd(flash_front_pkg::OPC_RD_SEG, 0, 0, 1, 8'h00);
    check("quad segment read", rdv[0], 8'h01);
    cmd(flash_front_pkg::OPC_EXIT_QUAD, 0, 0, 0, 8'h00);
    check("quad off", quad_mode, 0);
    $display("quad test done");
    for (int i = 0; i < 100 && expq.size() > 0; i++) @(posedge clk);
    check("notes left", expq.size(), 0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
